// *** rtl/daeac_ctrl.sv ***
// Top of the data EEPROM access controller: Avalon-MM register slave,
// unlock tracking, start control, power-up timer and programmer port.
// Assumes one 125 MHz clock; the master-clear pin is asynchronous.
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module daeac_ctrl #(
  parameter int PWRT_CYCLES  = daeac_pkg::PWRT_CYCLES_DEF,
  parameter int WRITE_CYCLES = daeac_pkg::WRITE_CYCLES_DEF
) (
  input  wire logic                      sys_clk,          // Core clock
  input  wire logic                      rst_n,            // Power-on reset
  input  wire logic                      masterClearReset, // Pin, high
  input  wire logic                      watchdogTimeout,  // Pulse, high
  input  wire logic                      codeProtect,      // Config bit
  input  wire logic [5:0]                avs_address,      // Byte address
  input  wire logic                      avs_read,         // Read request
  input  wire logic                      avs_write,        // Write request
  input  wire logic [31:0]               avs_writedata,    // Write data
  input  wire logic [3:0]                avs_byteenable,   // Byte lanes
  output logic      [31:0]               avs_readdata,     // Read data
  output logic                           avs_waitrequest,  // Stall
  input  wire daeac_pkg::daeac_ext_req_t extReq,           // Programmer req
  output logic      [7:0]                extRdata,         // Programmer data
  output logic                           extAck            // Req taken
);
  import daeac_pkg::*;

  localparam logic [PWRT_CNT_W-1:0] PWRT_LAST =
    PWRT_CNT_W'(PWRT_CYCLES - 1);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [ADDR_HI_W-1:0] addrHi;
  logic [7:0]           addrLo;
  logic [7:0]           dataByte;
  logic                 progMemSelect;
  logic                 configSpaceSelect;
  logic                 rowErase;
  logic                 writeError;
  logic                 writeEnable;
  logic                 writeStart;
  logic                 readStart;
  logic                 writeDoneFlag;
  logic                 writeDoneIrqEnable;
  logic                 writeDonePriority;
  logic [7:0]           globalIrqCtrl;
  daeac_unlock_t        ulState;
  logic [PWRT_CNT_W-1:0] pwrtCount;
  logic                 pwrtDone;
  logic                 mclrMeta;
  logic                 mclrSync;

  logic                 accept;
  logic                 wrAcc;
  logic [7:0]           wd;
  logic                 otherRst;
  logic                 arrBusy;
  logic                 arrDone;
  logic [7:0]           rdDataInt;
  logic [7:0]           rdDataExt;
  logic                 ctrlWr;
  logic                 startOk;
  logic                 extStart;
  logic [7:0]           rdMux;
  daeac_wr_cmd_t        wrCmd;
  logic [ADDR_W-1:0]    eeAddr;

  assign accept   = (avs_read || avs_write) && !avs_waitrequest;
  assign wrAcc    = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign wd       = avs_writedata[7:0];
  assign otherRst = mclrSync || watchdogTimeout;
  assign eeAddr   = {addrHi, addrLo};

  // ----------------------------------------------------------------------
  // Master-clear pin synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mclrMeta <= 1'b0;
      mclrSync <= 1'b0;
    end else begin
      mclrMeta <= masterClearReset;
      mclrSync <= mclrMeta;
    end
  end

  // ----------------------------------------------------------------------
  // Power-up timer
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pwrtCount <= '0;
      pwrtDone  <= 1'b0;
    end else if (!pwrtDone) begin
      if (pwrtCount == PWRT_LAST) begin
        pwrtDone <= 1'b1;
      end else begin
        pwrtCount <= pwrtCount + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Avalon-MM handshake: one wait cycle, then the access completes
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    rdMux = RST_BYTE;
    unique case (avs_address)
      OFF_ADDR_HI:  rdMux = {6'h00, addrHi};
      OFF_ADDR_LO:  rdMux = addrLo;
      OFF_DATA:     rdMux = dataByte;
      OFF_UNLOCK:   rdMux = 8'h00;
      OFF_CTRL:     rdMux = {progMemSelect, configSpaceSelect, 1'b0,
                             rowErase, writeError, writeEnable,
                             writeStart, readStart};
      OFF_IRQ_FLG:  rdMux = 8'(writeDoneFlag) << IRQ_WR_DONE;
      OFF_IRQ_EN:   rdMux = 8'(writeDoneIrqEnable) << IRQ_WR_DONE;
      OFF_IRQ_PRIO: rdMux = 8'(writeDonePriority) << IRQ_WR_DONE;
      OFF_GIRQ:     rdMux = globalIrqCtrl;
      default:      rdMux = 8'h00;
    endcase
  end

  // Read data is captured in the wait cycle and held through completion
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= {24'h00_0000, rdMux};
    end
  end

  // ----------------------------------------------------------------------
  // Unlock tracking
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n || otherRst) begin
      ulState <= UL_IDLE;
    end else if (accept) begin
      if (wrAcc && avs_address == OFF_UNLOCK && wd == UNLOCK_KEY1) begin
        ulState <= UL_GOT55;
      end else if (wrAcc && avs_address == OFF_UNLOCK &&
                   wd == UNLOCK_KEY2 && ulState == UL_GOT55) begin
        ulState <= UL_GOTAA;
      end else begin
        ulState <= UL_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Start decisions
  // ----------------------------------------------------------------------
  assign ctrlWr  = wrAcc && avs_address == OFF_CTRL && !arrBusy &&
                   !otherRst;
  // Old write-enable value is used, so a write that sets both while enable is clear starts no write
  assign startOk = ctrlWr && wd[CTRL_WR_START] && writeEnable &&
                   ulState == UL_GOTAA && pwrtDone &&
                   !wd[CTRL_PROG_SEL] && !wd[CTRL_CFG_SEL];
  assign extStart = extReq.wr && !codeProtect && !arrBusy &&
                    pwrtDone && !startOk && !otherRst;

  always_comb begin
    wrCmd.start = startOk || extStart;
    wrCmd.addr  = startOk ? eeAddr : extReq.addr;
    wrCmd.data  = startOk ? dataByte : extReq.data;
  end

  daeac_array #(
    .WR_CYCLES (WRITE_CYCLES)
  ) u_array (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .wrCmd     (wrCmd),
    .abort     (otherRst),
    .rdAddrInt (eeAddr),
    .rdDataInt (rdDataInt),
    .rdAddrExt (extReq.addr),
    .rdDataExt (rdDataExt),
    .busy      (arrBusy),
    .done      (arrDone)
  );

  // ----------------------------------------------------------------------
  // Address and data registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n || otherRst) begin
      addrHi <= '0;
      addrLo <= RST_BYTE;
    end else if (wrAcc && !arrBusy) begin
      if (avs_address == OFF_ADDR_HI) begin
        addrHi <= wd[ADDR_HI_W-1:0];
      end
      if (avs_address == OFF_ADDR_LO) begin
        addrLo <= wd;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || otherRst) begin
      dataByte <= RST_BYTE;
    end else if (readStart && !progMemSelect && !configSpaceSelect) begin
      dataByte <= rdDataInt;
    end else if (wrAcc && !arrBusy && avs_address == OFF_DATA) begin
      dataByte <= wd;
    end
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      progMemSelect     <= 1'b0;
      configSpaceSelect <= 1'b0;
      rowErase          <= 1'b0;
      writeEnable       <= 1'b0;
    end else if (ctrlWr) begin
      progMemSelect     <= wd[CTRL_PROG_SEL];
      configSpaceSelect <= wd[CTRL_CFG_SEL];
      rowErase          <= wd[CTRL_ROW_ERASE];
      writeEnable       <= wd[CTRL_WR_EN];
    end
  end

  // Start bits: software can only set them, hardware clears them
  always_ff @(posedge sys_clk) begin
    if (!rst_n || otherRst) begin
      writeStart <= 1'b0;
      readStart  <= 1'b0;
    end else begin
      if (startOk) begin
        writeStart <= 1'b1;
      end else if (arrDone) begin
        writeStart <= 1'b0;
      end
      if (readStart) begin
        readStart <= 1'b0;
      end else if (ctrlWr && wd[CTRL_RD_START] && !wd[CTRL_PROG_SEL] &&
                   !startOk) begin
        readStart <= 1'b1;
      end
    end
  end

  // An interrupted write is flagged; selects and row erase stay as they are
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      writeError <= 1'b0;
    end else if (otherRst && writeStart) begin
      writeError <= 1'b1;
    end else if (ctrlWr) begin
      writeError <= wd[CTRL_WR_ERR];
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt flag, enable, priority and global control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n || otherRst) begin
      writeDoneFlag <= 1'b0;
    end else if (arrDone && writeStart) begin
      writeDoneFlag <= 1'b1;
    end else if (wrAcc && avs_address == OFF_IRQ_FLG) begin
      writeDoneFlag <= wd[IRQ_WR_DONE];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || otherRst) begin
      writeDoneIrqEnable <= 1'b0;
      writeDonePriority  <= RST_PRIO;
      globalIrqCtrl      <= RST_BYTE;
    end else if (wrAcc) begin
      if (avs_address == OFF_IRQ_EN) begin
        writeDoneIrqEnable <= wd[IRQ_WR_DONE];
      end
      if (avs_address == OFF_IRQ_PRIO) begin
        writeDonePriority <= wd[IRQ_WR_DONE];
      end
      if (avs_address == OFF_GIRQ) begin
        globalIrqCtrl <= wd;
      end
    end
  end

  // ----------------------------------------------------------------------
  // External programming port
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      extRdata <= 8'h00;
      extAck   <= 1'b0;
    end else begin
      extAck <= extReq.rd || extReq.wr;
      if (extReq.rd) begin
        extRdata <= codeProtect ? 8'h00 : rdDataExt;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_start_unlocked: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(writeStart) |-> $past(ulState) == UL_GOTAA)
    else $error("Write began without the unlock pair");

  a_start_enabled: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(writeStart) |-> $past(writeEnable))
    else $error("Write began while write enable was clear");

  a_enable_sticky: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    writeEnable && !ctrlWr |=> writeEnable)
    else $error("Write enable dropped without software");

  a_regs_frozen: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    arrBusy && writeStart && !otherRst |=>
      $stable(addrLo) && $stable(dataByte) && $stable(writeEnable))
    else $error("Register changed during a write");

  a_done_sets_flag: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    arrDone && writeStart && !otherRst |=> writeDoneFlag && !writeStart)
    else $error("Write end did not flag or clear start");

  a_flag_held: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    writeDoneFlag && !otherRst &&
      !(wrAcc && avs_address == OFF_IRQ_FLG) |=> writeDoneFlag)
    else $error("Write done flag lost without a clear");

  a_read_loads: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    readStart && !progMemSelect && !configSpaceSelect && !otherRst
      |=> dataByte == $past(rdDataInt) && !readStart)
    else $error("Read did not load the data register");

  a_pwrt_blocks: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !pwrtDone |-> !arrBusy && !writeStart)
    else $error("Write ran during the power-up timer");

  a_ext_protect: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    extReq.rd && codeProtect |=> extRdata == 8'h00 && extAck)
    else $error("Protected array was read externally");

  a_abort_error: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    otherRst && writeStart |=> writeError && !writeStart && !arrBusy)
    else $error("Interrupted write not flagged");

  a_unlock_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    avs_read && avs_waitrequest && avs_address == OFF_UNLOCK
      |=> avs_readdata == 32'h0000_0000 && !avs_waitrequest)
    else $error("Unlock register read not zero");

endmodule : daeac_ctrl
`default_nettype wire

// *** rtl/daeac_pkg.sv ***
// Package for the data EEPROM access controller: offsets, fields, resets,
// timing counts, the unlock states and the carrier structs.
// Assumes a single 125 MHz core clock and a 32-bit Avalon-MM register bus.

package daeac_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [5:0] OFF_ADDR_HI  = 6'h00;
  localparam logic [5:0] OFF_ADDR_LO  = 6'h04;
  localparam logic [5:0] OFF_DATA     = 6'h08;
  localparam logic [5:0] OFF_UNLOCK   = 6'h0C;
  localparam logic [5:0] OFF_CTRL     = 6'h10;
  localparam logic [5:0] OFF_IRQ_FLG  = 6'h14;
  localparam logic [5:0] OFF_IRQ_EN   = 6'h18;
  localparam logic [5:0] OFF_IRQ_PRIO = 6'h1C;
  localparam logic [5:0] OFF_GIRQ     = 6'h20;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_PROG_SEL  = 7;
  localparam int CTRL_CFG_SEL   = 6;
  localparam int CTRL_ROW_ERASE = 4;
  localparam int CTRL_WR_ERR    = 3;
  localparam int CTRL_WR_EN     = 2;
  localparam int CTRL_WR_START  = 1;
  localparam int CTRL_RD_START  = 0;
  localparam int IRQ_WR_DONE    = 4;
  localparam int ADDR_W         = 10;
  localparam int ADDR_HI_W      = 2;
  localparam int EE_DEPTH       = 1024;

  // ----------------------------------------------------------------------
  // Reset values and keys
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic       RST_PRIO      = 1'b1;
  localparam logic [7:0] UNLOCK_KEY1   = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2   = 8'hAA;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ           = 125_000_000;
  localparam int PWRT_TIME_MS     = 72;
  localparam int PWRT_CYCLES_DEF  = PWRT_TIME_MS * (CLK_HZ / 1000);
  localparam int PWRT_CNT_W       = 24;
  localparam int WRITE_TIME_US    = 4;
  localparam int WRITE_CYCLES_DEF = WRITE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int WRITE_CNT_W      = 24;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    UL_IDLE  = 2'b00,
    UL_GOT55 = 2'b01,
    UL_GOTAA = 2'b11
  } daeac_unlock_t;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } daeac_ext_req_t;

  typedef struct packed {
    logic              start;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } daeac_wr_cmd_t;

endpackage : daeac_pkg

// *** rtl/daeac_array.sv ***
// EEPROM byte array with a self-timed erase-then-program write.
// Assumes the caller starts a write only while busy is low.
`timescale 1ns/1ps
`default_nettype none

module daeac_array #(
  parameter int WR_CYCLES = daeac_pkg::WRITE_CYCLES_DEF
) (
  input  wire logic                      sys_clk,   // Core clock
  input  wire logic                      rst_n,     // Sync reset, low
  input  wire daeac_pkg::daeac_wr_cmd_t  wrCmd,     // Write start request
  input  wire logic                      abort,     // Kill running write
  input  wire logic [9:0]                rdAddrInt, // Core read address
  output logic      [7:0]                rdDataInt, // Core read data
  input  wire logic [9:0]                rdAddrExt, // Programmer address
  output logic      [7:0]                rdDataExt, // Programmer data
  output logic                           busy,      // Write in progress
  output logic                           done       // Write finished pulse
);
  import daeac_pkg::*;

  localparam logic [WRITE_CNT_W-1:0] WR_LAST = WRITE_CNT_W'(WR_CYCLES - 1);

  logic [7:0]             mem [EE_DEPTH];
  logic [WRITE_CNT_W-1:0] timer;
  logic [ADDR_W-1:0]      wAddr;
  logic [7:0]             wData;

  assign rdDataInt = mem[rdAddrInt];
  assign rdDataExt = mem[rdAddrExt];

  // ----------------------------------------------------------------------
  // Self-timed write
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy  <= 1'b0;
      done  <= 1'b0;
      timer <= '0;
      wAddr <= '0;
      wData <= RST_BYTE;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (wrCmd.start && !busy) begin
        busy  <= 1'b1;
        timer <= '0;
        wAddr <= wrCmd.addr;
        wData <= wrCmd.data;
      end else if (busy) begin
        if (timer == WR_LAST) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          timer <= timer + 1'b1;
        end
      end
    end
  end

  // Erase then program lands as one update at the end of the timed cycle;
  // an aborted write leaves the old byte in place.
  always_ff @(posedge sys_clk) begin
    if (busy && !abort && timer == WR_LAST) begin
      mem[wAddr] <= wData;
    end
  end

endmodule : daeac_array
`default_nettype wire

// *** testbench/daeac_prog_model.sv ***
// Model of the external programmer at the programmer port.
// Assumes ack and read data follow a request by one cycle.
`timescale 1ns/1ps
`default_nettype none
module daeac_prog_model (
  input  wire logic                  sys_clk,  // Core clock
  input  wire logic                  rdGo,     // One-cycle read trigger
  input  wire logic                  wrGo,     // One-cycle write trigger
  input  wire logic [9:0]            addr,     // Address to read or write
  input  wire logic                  extAck,   // Request taken
  input  wire logic [7:0]            extRdata, // Read data
  output var  daeac_pkg::daeac_ext_req_t extReq, // Port request
  output var  logic [7:0]            got       // Last data taken
);
  import daeac_pkg::*;
  logic [17:0] idle = 18'h2AAAA;
  always @(posedge sys_clk) begin
    idle <= ~idle;
    // Idle fields toggle so stale values never pass for a request
    extReq <= rdGo ? {2'b10, addr, 8'h00} :
              wrGo ? {2'b01, addr, 8'h5A} : {2'b00, idle};
    if (extAck) got <= extRdata;
  end
endmodule : daeac_prog_model
`default_nettype wire

// *** testbench/test_data_eeprom_access_ctrl.sv ***
// Self-checking bench for the data EEPROM access controller.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_data_eeprom_access_ctrl;
  import daeac_pkg::*;
  logic sys_clk, rst_n, codeProtect, avs_read, avs_write, rdGo, wrGo, wdt;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic avs_waitrequest, extAck;
  logic [7:0] extRdata, got, q;
  daeac_ext_req_t extReq;
  int fails = 0, checks = 0, cyc = 0;
  localparam logic [5:0] RA [10] = '{OFF_ADDR_HI, OFF_ADDR_LO, OFF_DATA,
    OFF_UNLOCK, OFF_CTRL, OFF_IRQ_FLG, OFF_IRQ_EN, OFF_IRQ_PRIO, OFF_GIRQ,
    6'h24};
  localparam logic [7:0] RE [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
  daeac_ctrl #(.PWRT_CYCLES(20), .WRITE_CYCLES(8)) i_daeac_ctrl (
    .sys_clk, .rst_n, .masterClearReset(1'b0), .watchdogTimeout(wdt),
    .codeProtect, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .extReq,
    .extRdata, .extAck);
  daeac_prog_model i_daeac_prog_model (.sys_clk, .rdGo, .wrGo, .addr(10'h312),
    .extAck, .extRdata, .extReq, .got);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      results();
    end
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [7:0] d);
    @(posedge sys_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask : rc
  task automatic unlock(input logic [7:0] k1, input logic [7:0] k2);
    bus(1'b1, OFF_UNLOCK, k1);
    bus(1'b1, OFF_UNLOCK, k2);
  endtask : unlock
  // Programmer access; a write waits out the self-timed array cycle
  task automatic ext(input logic w, input logic [7:0] e);
    @(posedge sys_clk);
    rdGo <= !w;
    wrGo <= w;
    @(posedge sys_clk);
    rdGo <= 1'b0;
    wrGo <= 1'b0;
    repeat (12) @(posedge sys_clk);
    if (!w) chk(got, e);
  endtask : ext
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  initial begin
    rst_n = 1'b0;
    codeProtect = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h00000000;
    rdGo = 1'b0;
    wrGo = 1'b0;
    wdt = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) rc(RA[i], RE[i]);
    $display("test reset values ended");
    bus(1'b1, OFF_ADDR_HI, 8'hFF);
    rc(OFF_ADDR_HI, 8'h03);
    bus(1'b1, OFF_ADDR_LO, 8'h12);
    bus(1'b1, OFF_DATA, 8'hA5);
    bus(1'b1, OFF_CTRL, 8'h04);
    bus(1'b1, OFF_GIRQ, 8'h00);
    unlock(UNLOCK_KEY1, UNLOCK_KEY2);
    bus(1'b1, OFF_CTRL, 8'h06);
    rc(OFF_CTRL, 8'h06);
    bus(1'b1, OFF_DATA, 8'h00);
    rc(OFF_DATA, 8'hA5);
    repeat (20) @(posedge sys_clk);
    rc(OFF_CTRL, 8'h04);
    rc(OFF_IRQ_FLG, 8'h10);
    bus(1'b1, OFF_IRQ_FLG, 8'h00);
    rc(OFF_IRQ_FLG, 8'h00);
    $display("test unlocked write ended");
    codeProtect <= 1'b1;
    bus(1'b1, OFF_DATA, 8'h00);
    bus(1'b1, OFF_CTRL, 8'h05);
    rc(OFF_DATA, 8'hA5);
    rc(OFF_DATA, 8'hA5);
    rc(OFF_CTRL, 8'h04);
    ext(1'b0, 8'h00);
    codeProtect <= 1'b0;
    ext(1'b0, 8'hA5);
    $display("test read and protect ended");
    bus(1'b1, OFF_DATA, 8'h3C);
    bus(1'b1, OFF_UNLOCK, UNLOCK_KEY1);
    rc(OFF_UNLOCK, 8'h00);
    bus(1'b1, OFF_UNLOCK, UNLOCK_KEY2);
    bus(1'b1, OFF_CTRL, 8'h06);
    rc(OFF_CTRL, 8'h04);
    unlock(UNLOCK_KEY2, UNLOCK_KEY1);
    bus(1'b1, OFF_CTRL, 8'h06);
    rc(OFF_CTRL, 8'h04);
    bus(1'b1, OFF_CTRL, 8'h00);
    unlock(UNLOCK_KEY1, UNLOCK_KEY2);
    bus(1'b1, OFF_CTRL, 8'h06);
    rc(OFF_CTRL, 8'h04);
    repeat (20) @(posedge sys_clk);
    rc(OFF_IRQ_FLG, 8'h00);
    bus(1'b1, OFF_CTRL, 8'h05);
    rc(OFF_DATA, 8'hA5);
    $display("test refused writes ended");
    bus(1'b1, OFF_DATA, 8'h77);
    unlock(UNLOCK_KEY1, UNLOCK_KEY2);
    bus(1'b1, OFF_CTRL, 8'h06);
    @(posedge sys_clk);
    wdt <= 1'b1;
    @(posedge sys_clk);
    wdt <= 1'b0;
    rc(OFF_CTRL, 8'h0C);
    rc(OFF_ADDR_LO, 8'h00);
    bus(1'b1, OFF_ADDR_HI, 8'h03);
    bus(1'b1, OFF_ADDR_LO, 8'h12);
    bus(1'b1, OFF_CTRL, 8'h05);
    rc(OFF_DATA, 8'hA5);
    $display("test interrupted write ended");
    codeProtect <= 1'b1;
    ext(1'b1, 8'h00);
    codeProtect <= 1'b0;
    ext(1'b0, 8'hA5);
    ext(1'b1, 8'h00);
    ext(1'b0, 8'h5A);
    bus(1'b1, OFF_CTRL, 8'h05);
    rc(OFF_DATA, 8'h5A);
    $display("test programmer writes ended");
    results();
  end
endmodule : test_data_eeprom_access_ctrl
`default_nettype wire
